//--- verilog/step_dir_pulse_output.sv
// Step/direction output stage: turns step requests into step and direction lines.
// Assumes step requests and register accesses come from logic on clk_sys_i (50 MHz).
`timescale 1ns/1ps
`default_nettype none
`include "step_dir_defines.svh"

module step_dir_pulse_output
    import step_dir_pkg::*;
(
    input  wire logic                   clk_sys_i,
    input  wire logic                   reset_n_i,
    input  wire step_dir_pkg::reg_req_t reg_req_i,
    output logic [31:0]                 reg_rdata_o,
    output logic                        reg_rvalid_o,
    input  wire step_dir_pkg::step_req_t step_req_i,
    output logic                        step_ready_o,
    output logic                        step_pulse_out_o,
    output logic                        direction_out_o
);
    import step_dir_pkg::*;

    // Registers, sequencer state and timer hookup
    logic [31:0]          global_config_q;
    logic [31:0]          step_timing_q;
    seq_state_t           state_q;
    seq_state_t           state_d;
    logic                 pending_q;
    logic                 pending_neg_q;
    logic                 dir_q;
    logic                 step_out_q;
    logic                 ready_q;
    logic                 timer_load;
    logic [`SD_CNT_W-1:0] timer_value;
    logic                 timer_zero;
    logic                 want_dir;
    logic                 start_pulse;
    logic                 flip_dir;
    logic                 pulse_active_d;
    logic [`SD_CNT_W-1:0] extra_pulse_width;
    logic [`SD_CNT_W-1:0] direction_lead_time;
    logic [31:0]          status_word;

    // Both timing fields live in one register word
    assign extra_pulse_width   = step_timing_q[`SD_PW_MSB:`SD_PW_LSB];
    assign direction_lead_time = step_timing_q[`SD_LEAD_MSB:`SD_LEAD_LSB];

    // Register writes; both timing fields share one word
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            global_config_q <= `SD_RST_GLOBAL_CONFIG;
            step_timing_q   <= `SD_RST_STEP_TIMING;
        end else if (reg_req_i.wr) begin
            if (reg_req_i.addr == `SD_OFS_GLOBAL_CONFIG) begin
                global_config_q <= reg_req_i.wdata;
            end
            if (reg_req_i.addr == `SD_OFS_STEP_TIMING) begin
                step_timing_q <= reg_req_i.wdata;
            end
        end
    end

    // Status word: state, pending, ready, direction, step line
    assign status_word = {26'h0,
                          state_q,
                          pending_q,
                          ready_q,
                          dir_q,
                          step_out_q};

    // Registered read answer, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o  <= 32'h0000_0000;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_req_i.rd;
            if (reg_req_i.rd) begin
                unique case (reg_req_i.addr)
                    `SD_OFS_GLOBAL_CONFIG: reg_rdata_o <= global_config_q;
                    `SD_OFS_STEP_TIMING:   reg_rdata_o <= step_timing_q;
                    `SD_OFS_STATUS:        reg_rdata_o <= status_word;
                    default:               reg_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Direction level for the pending step, sense bit picks the mapping
    assign want_dir = global_config_q[`SD_BIT_DIR_SENSE] ? pending_neg_q
                                                         : ~pending_neg_q;

    // Accepted request waits here; requests are only taken in idle
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pending_q     <= 1'b0;
            pending_neg_q <= 1'b0;
        end else if (step_req_i.valid && ready_q) begin
            pending_q     <= 1'b1;
            pending_neg_q <= step_req_i.negative;
        end else if (start_pulse) begin
            pending_q     <= 1'b0;
        end
    end

    // Sequencer: idle -> (lead) -> pulse -> hold -> idle
    always_comb begin
        state_d     = state_q;
        timer_load  = 1'b0;
        timer_value = '0;
        start_pulse = 1'b0;
        flip_dir    = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (pending_q && (want_dir != dir_q)) begin
                    flip_dir    = 1'b1;
                    timer_load  = 1'b1;
                    timer_value = direction_lead_time;
                    state_d     = ST_LEAD;
                end else if (pending_q) begin
                    start_pulse = 1'b1;
                end
            end
            ST_LEAD: begin
                if (timer_zero) begin
                    start_pulse = 1'b1;
                end
            end
            ST_PULSE: begin
                if (timer_zero) begin
                    timer_load  = 1'b1;
                    timer_value = extra_pulse_width;
                    state_d     = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (timer_zero) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
        if (start_pulse) begin
            timer_load  = 1'b1;
            timer_value = extra_pulse_width;
            state_d     = ST_PULSE;
        end
    end

    // State register; only one step is ever in flight
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Direction only moves from idle, never in pulse or hold
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dir_q <= 1'b0;
        end else if (flip_dir) begin
            dir_q <= want_dir;
        end
    end

    // Look ahead so the step line moves with the state, not a cycle late
    assign pulse_active_d = (state_d == ST_PULSE);

    // Step line; toggle mode keeps its level between steps
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            step_out_q <= 1'b0;
        end else if (global_config_q[`SD_BIT_EDGE_PER_STEP]) begin
            if (start_pulse) begin
                step_out_q <= ~step_out_q;
            end
        end else begin
            // Idle level bit set makes the falling edge the step
            step_out_q <= pulse_active_d ^ global_config_q[`SD_BIT_PULSE_IDLE];
        end
    end

    // Ready drops as soon as a request is taken, so none is lost
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= (state_d == ST_IDLE) && !pending_q && !(step_req_i.valid && ready_q);
        end
    end

    // One shared timer: lead, pulse and hold never overlap
    step_timer u_timer (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .load_i    (timer_load),
        .value_i   (timer_value),
        .zero_o    (timer_zero)
    );

    // Outputs straight from their flip-flops
    assign step_pulse_out_o = step_out_q;
    assign direction_out_o  = dir_q;
    assign step_ready_o     = ready_q;

endmodule : step_dir_pulse_output

`default_nettype wire

//--- verilog/step_dir_defines.svh
// Offsets, field positions, reset values and timing figures of the step/direction stage.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef STEP_DIR_DEFINES_SVH
`define STEP_DIR_DEFINES_SVH

// Register offsets on the internal register port
`define SD_OFS_GLOBAL_CONFIG  8'h00
`define SD_OFS_STEP_TIMING    8'h10
`define SD_OFS_STATUS         8'h7f

// Field positions in global_config
`define SD_BIT_PULSE_IDLE     3
`define SD_BIT_EDGE_PER_STEP  4
`define SD_BIT_DIR_SENSE      5

// Field positions in the shared timing word
`define SD_PW_LSB             0
`define SD_PW_MSB             15
`define SD_LEAD_LSB           16
`define SD_LEAD_MSB           31

// Reset values: direction sense default one, no extra width or lead
`define SD_RST_GLOBAL_CONFIG  32'h0000_0020
`define SD_RST_STEP_TIMING    32'h0000_0000

// Counter width for both timing fields
`define SD_CNT_W              16

`endif

//--- verilog/step_dir_pkg.sv
// Types shared by the step/direction output stage.
// Assumes step_dir_defines.svh is reachable on the include path.
`include "step_dir_defines.svh"

package step_dir_pkg;

    // Register port request, same clock as the stage
    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic [31:0] wdata;
    } reg_req_t;

    // Step request from the ramp generator
    typedef struct packed {
        logic valid;
        logic negative;
    } step_req_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LEAD  = 2'b01,
        ST_PULSE = 2'b10,
        ST_HOLD  = 2'b11
    } seq_state_t;

endpackage : step_dir_pkg

//--- verilog/step_timer.sv
// Loadable down counter with a zero flag, used for pulse, hold and lead timing.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "step_dir_defines.svh"

module step_timer (
    input  wire logic                  clk_sys_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  load_i,
    input  wire logic [`SD_CNT_W-1:0]  value_i,
    output logic                       zero_o
);
    logic [`SD_CNT_W-1:0] count_q;

    // Load wins over counting; stops at zero
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_q <= '0;
        end else if (load_i) begin
            count_q <= value_i;
        end else if (count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end

    assign zero_o = (count_q == '0);

endmodule : step_timer

`default_nettype wire

//--- sim/step_dir_pulse_output_asserts.sv
// Port checker for the step/direction stage.
// Assumes it is bound into step_dir_pulse_output.
`timescale 1ns/1ps
`default_nettype none
`include "step_dir_defines.svh"
module step_dir_pulse_output_asserts
    import step_dir_pkg::*;
(
    input wire logic                    clk_sys_i,
    input wire logic                    reset_n_i,
    input wire step_dir_pkg::reg_req_t  reg_req_i,
    input wire logic [31:0]             reg_rdata_o,
    input wire logic                    reg_rvalid_o,
    input wire step_dir_pkg::step_req_t step_req_i,
    input wire logic                    step_ready_o,
    input wire logic                    step_pulse_out_o,
    input wire logic                    direction_out_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    logic [15:0] lead_q;
    logic        dir_prev_q;
    int          since_dir_q;
    // Shadow of the lead field and cycles since the direction line last moved
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lead_q      <= 16'h0000;
            dir_prev_q  <= 1'b0;
            since_dir_q <= 32'h0001_0000;
        end else begin
            if (reg_req_i.wr && reg_req_i.addr == `SD_OFS_STEP_TIMING) begin
                lead_q <= reg_req_i.wdata[`SD_LEAD_MSB:`SD_LEAD_LSB];
            end
            dir_prev_q <= direction_out_o;
            if (direction_out_o != dir_prev_q) begin
                since_dir_q <= 0;
            end else if (since_dir_q < 32'h0001_0000) begin
                since_dir_q <= since_dir_q + 1;
            end
        end
    end
    // Read answer is a one-cycle pulse
    a_rd_answer: assert property (
        reg_req_i.rd |=> reg_rvalid_o) else $error("read not answered");
    a_rvalid_pulse: assert property (
        !reg_req_i.rd |=> !reg_rvalid_o) else $error("stray read valid");
    // Step handshake; the line never moves in the cycle after a take
    a_ready_drop: assert property (
        step_req_i.valid && step_ready_o |=> !step_ready_o) else $error("ready stayed");
    a_take_quiet: assert property (
        step_req_i.valid && step_ready_o |=> $stable(step_pulse_out_o)) else $error("early");
    // Direction and step lines never move together or too close
    a_lead_gap: assert property (
        $changed(step_pulse_out_o) |-> since_dir_q >= lead_q) else $error("no lead");
    a_dir_still: assert property (
        $changed(step_pulse_out_o) |-> $stable(direction_out_o)) else $error("dir in pulse");
    a_dir_hold: assert property (
        $changed(step_pulse_out_o) |=> $stable(direction_out_o)[*2]) else $error("dir in hold");
    a_dir_busy: assert property (
        $changed(direction_out_o) |-> !step_ready_o) else $error("dir moved idle");
endmodule : step_dir_pulse_output_asserts

bind step_dir_pulse_output step_dir_pulse_output_asserts i_chk (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .step_req_i(step_req_i),
    .step_ready_o(step_ready_o), .step_pulse_out_o(step_pulse_out_o),
    .direction_out_o(direction_out_o));
`default_nettype wire

//--- sim/step_driver_model.sv
// Stepper driver model: counts steps, measures width and direction lead.
// Assumes both lines are sampled on the system clock.
`timescale 1ns/1ps
`default_nettype none
module step_driver_model (
    input  wire logic clk_sys_i,
    input  wire logic step_i,
    input  wire logic dir_i,
    input  wire logic pol_i,
    input  wire logic tog_i,
    output var  int   steps_o,
    output var  int   width_o,
    output var  int   lead_o,
    output logic      dir_o
);
    int   act_q;
    int   gap_q;
    logic step_q = 1'b0;
    logic dir_q  = 1'b0;
    logic ev;
    // Step edge as the driver sees it
    assign ev = tog_i ? step_i != step_q
              : (pol_i ? step_q & ~step_i : ~step_q & step_i);
    // Width counts active samples; lead counts edges since a direction move
    always @(posedge clk_sys_i) begin
        step_q <= step_i;
        dir_q  <= dir_i;
        gap_q  <= (dir_i != dir_q) ? 0 : gap_q + 1;
        act_q  <= (step_i != pol_i) ? act_q + 1 : 0;
        if (step_i == pol_i && act_q != 0)
            width_o <= act_q;
        if (ev) begin
            steps_o <= steps_o + 1;
            dir_o   <= dir_i;
            lead_o  <= gap_q + 1;
        end
    end
endmodule : step_driver_model
`default_nettype wire

//--- sim/tb.sv
// Testbench for the step/direction stage with a driver model.
// Assumes the design package and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import step_dir_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        reset_n_i = 1'b0;
    reg_req_t    reg_req_i = '0;
    step_req_t   step_req_i = '0;
    logic [31:0] reg_rdata_o;
    logic [31:0] cfg = 32'h0000_0020;
    logic        reg_rvalid_o, step_ready_o, step_pulse_out_o, direction_out_o, dir_seen;
    int          err_total = 0, num_checks = 0, cycles = 0, steps, width, lead;
    // Per entry: config, then bit i of request sign, expected line, direction move
    logic [7:0]  cfgs [8] = '{8'h20, 8'h20, 8'h00, 8'h00, 8'h08, 8'h00, 8'h10, 8'h10};
    logic [7:0]  negs = 8'b0000_0110;
    logic [7:0]  dirs = 8'b1111_1010;
    logic [7:0]  chgs = 8'b0000_1110;

    step_dir_pulse_output i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .step_req_i(step_req_i), .step_ready_o(step_ready_o),
        .step_pulse_out_o(step_pulse_out_o), .direction_out_o(direction_out_o));
    step_driver_model i_drv (.clk_sys_i(clk_sys_i), .step_i(step_pulse_out_o),
        .dir_i(direction_out_o), .pol_i(cfg[3]), .tog_i(cfg[4]), .steps_o(steps),
        .width_o(width), .lead_o(lead), .dir_o(dir_seen));

    // 50 MHz clock
    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i) reg_req_i <= '{a, 1'b1, 1'b0, d};
        @(posedge clk_sys_i) reg_req_i.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys_i) reg_req_i <= '{a, 1'b0, 1'b1, 32'h0};
        @(posedge clk_sys_i) reg_req_i.rd <= 1'b0;
        #1 check(what, reg_rdata_o, exp);
    endtask : rd

    // Hold the request until taken, then wait for the stage to go idle
    task automatic step(input logic neg);
        @(posedge clk_sys_i) step_req_i <= '{1'b1, neg};
        do @(negedge clk_sys_i); while (step_ready_o !== 1'b1);
        @(posedge clk_sys_i) step_req_i.valid <= 1'b0;
        @(posedge clk_sys_i);
        do @(negedge clk_sys_i); while (step_ready_o !== 1'b1);
    endtask : step

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // Cut a hang short; the whole run needs well under a thousand cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            complete_run();
        end
    end

    // Registers first, then one step per table entry with width 3 and lead 4
    initial begin
        repeat (12) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rd(8'h00, 32'h0000_0020, "config");
        rd(8'h10, 32'h0000_0000, "timing");
        wr(8'h10, 32'h0003_0002);
        wr(8'h55, 32'hffff_ffff);
        rd(8'h10, 32'h0003_0002, "timing");
        rd(8'h55, 32'h0000_0000, "unmapped");
        rd(8'h7f, 32'h0000_0004, "status");
        $display("test registers done");
        foreach (cfgs[i]) begin
            cfg = {24'h0, cfgs[i]};
            wr(8'h00, cfg);
            step(negs[i]);
            check("steps", steps, i + 1);
            check("direction", dir_seen, dirs[i]);
            if (!cfg[4]) check("width", width, 3);
            if (chgs[i]) check("lead", lead, 4);
            $display("test step %0d done", i);
        end
        complete_run();
    end
endmodule : tb
`default_nettype wire
